// File: verilog/dcm_pkg.sv
// shared constants, types and helpers for the dual clock mailbox fifo
package dcm_pkg;

    localparam int          DCM_DATA_W         = 36;
    localparam int          DCM_ADDR_W         = 10;
    localparam int          DCM_PTR_W          = 11;
    localparam int          DCM_OFS_W          = 10;
    localparam logic [10:0] DCM_DEPTH_PTR      = 11'h400;
    localparam logic [10:0] DCM_PTR_ONE        = 11'h001;
    localparam logic [10:0] DCM_PTR_RESET      = 11'h000;
    localparam logic [9:0]  DCM_PRESET_HI_OFS  = 10'h040;
    localparam logic [9:0]  DCM_PRESET_LO_OFS  = 10'h008;
    localparam logic [9:0]  DCM_OFS_RESET      = 10'h040;
    localparam logic [4:0]  DCM_SERIAL_BITS    = 5'h14;
    localparam logic [1:0]  DCM_IR_WAIT_EDGES  = 2'h2;
    localparam logic [1:0]  DCM_FS_SERIAL      = 2'h3;
    localparam logic [1:0]  DCM_FS_PRESET_HI   = 2'h2;
    localparam logic [1:0]  DCM_FS_PRESET_LO   = 2'h1;
    localparam logic [35:0] DCM_WORD_RESET     = 36'h0;

    typedef enum logic [2:0] {
        CFG_HOLD,
        CFG_WAIT,
        CFG_SERIAL,
        CFG_LOAD_FULL,
        CFG_LOAD_EMPTY,
        CFG_RUN
    } dcm_cfg_type;

    // per-port strobes; dir is write for side a and read for side b
    typedef struct packed {
        logic cs_n;
        logic gate;
        logic dir;
        logic mbx;
    } dcm_port_ctl_type;

    typedef struct packed {
        logic             a_clk;
        logic             b_clk;
        logic             rst_n;
        logic             fs_hi;
        logic             fs_lo;
        logic             retransmit_mark;
        logic             replay_from_mark;
        dcm_port_ctl_type a_ctl;
        dcm_port_ctl_type b_ctl;
        logic [35:0]      a_data;
        logic [35:0]      b_data;
    } dcm_pins_type;

    function automatic logic [10:0] dcm_ptr_diff(input logic [10:0] hi, input logic [10:0] lo);
        dcm_ptr_diff = hi - lo;
    endfunction

endpackage

// File: verilog/dcm_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module dcm_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_ff <= '0;
            q_o     <= '0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule

// File: verilog/dcm_mem.sv
// word array with registered read data
`timescale 1ns/100ps
module dcm_mem #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 10
) (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              rd_en_i,
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [DATA_W-1:0] rd_data_o
);
    logic [DATA_W-1:0] mem_ff [2**ADDR_W];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_ff[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_data_o <= '0;
        end else if (rd_en_i) begin
            rd_data_o <= mem_ff[rd_addr_i];
        end
    end
endmodule

// File: verilog/dcm_mailbox_fifo.sv
// dual clock mailbox fifo, port clocks oversampled on clk_i
//
// Operation
// R1 - near empty low while stored words at or below empty offset
// R2 - near full low while free locations at or below full offset
// R3 - each side has a 36-bit two-way data bus
// R4 - side a flags move on a edges, side b flags on b edges
// R5 - transfers need chip select low; bus floats while it is high
// R6 - transfers need the master gate high
// R7 - host holds reset low over four edges of each port clock
// R8 - offset select pair sampled at reset release picks programming method
// R9 - offset select pins become shift gate and serial bit after serial select
// R10 - a edge with shift gate low shifts serial bit into offset chain
// R11 - twenty serial bits, full offset msb first, empty offset lsb last
// R12 - accept flag low blocks writes; low when full or reaching mark
// R13 - accept flag low in reset, raised after reset completes
// R14 - side a mailbox select routes access to a mailbox
// R15 - side b bus shows mailbox when selected, else output register
// R16 - a write of mailbox to b lowers its flag; b read or reset raises
// R17 - b write of mailbox to a lowers its flag; a read or reset raises
// R18 - valid flag low means empty and no reads; high holds a word
// R19 - valid flag low in reset, rises third b edge after first word
// R20 - mark high with valid word records start, enters retransmit
// R21 - start held until a b edge with mark low ends retransmit
// R22 - replay in retransmit rewinds read pointer and loads start word
// R23 - pair high/high serial, high/low 64, low/high 8, low/low parallel
// R24 - parallel mode: first two writes load full then empty offset
// R25 - fifo write needs select low, mailbox low, write, gate, accept
// R26 - fifo read needs select low, mailbox low, read, gate, valid
// R27 - pointers cross between port sides through two staged copies
// R28 - array of 1024 words, pointers wrap and clear on reset
`timescale 1ns/100ps
module dcm_mailbox_fifo
    import dcm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        a_side_clock_i,
    input  wire logic        b_side_clock_i,
    input  wire logic        device_reset_n_i,
    input  wire logic        offset_select_hi_or_serial_shift_gate_i,
    input  wire logic        offset_select_lo_or_serial_bit_in_i,
    input  wire logic        a_side_chip_select_n_i,
    input  wire logic        a_side_master_gate_i,
    input  wire logic        a_side_write_not_read_i,
    input  wire logic        a_side_mailbox_select_i,
    input  wire logic        b_side_chip_select_n_i,
    input  wire logic        b_side_master_gate_i,
    input  wire logic        b_side_read_not_write_i,
    input  wire logic        b_side_mailbox_select_i,
    input  wire logic        retransmit_mark_i,
    input  wire logic        replay_from_mark_i,
    input  wire logic [35:0] a_side_data_bus_i,
    output logic      [35:0] a_side_data_bus_o,
    output logic             a_side_data_bus_oe_o,
    input  wire logic [35:0] b_side_data_bus_i,
    output logic      [35:0] b_side_data_bus_o,
    output logic             b_side_data_bus_oe_o,
    output logic             input_accept_flag_o,
    output logic             near_full_flag_n_o,
    output logic             output_valid_flag_o,
    output logic             near_empty_flag_n_o,
    output logic             mail_to_b_flag_n_o,
    output logic             mail_to_a_flag_n_o
);
    dcm_pins_type pins_raw;
    dcm_pins_type pins_s;
    dcm_cfg_type  cfg_ff;
    dcm_cfg_type  nxt_cfg;

    logic        a_clk_d_ff;
    logic        b_clk_d_ff;
    logic        rst_n_d_ff;
    logic        par_mode_ff;
    logic [1:0]  wait_cnt_ff;
    logic [4:0]  bit_cnt_ff;
    logic [9:0]  full_ofs_ff;
    logic [9:0]  empty_ofs_ff;
    logic [10:0] wr_ptr_ff;
    logic [10:0] rd_ptr_ff;
    logic [10:0] mark_ptr_ff;
    logic [10:0] wr_b1_ff;
    logic [10:0] wr_b2_ff;
    logic [10:0] free_a1_ff;
    logic [10:0] free_a2_ff;
    logic        rtx_ff;
    logic        load_pend_ff;
    logic [35:0] out_reg_ff;
    logic [35:0] mbx_to_b_ff;
    logic [35:0] mbx_to_a_ff;
    logic [35:0] mem_q;
    logic        nxt_ir;

    // port clocks and strobes are foreign to clk_i, so every pin is synchronised
    assign pins_raw = '{a_clk: a_side_clock_i, b_clk: b_side_clock_i, rst_n: device_reset_n_i,
                        fs_hi: offset_select_hi_or_serial_shift_gate_i,
                        fs_lo: offset_select_lo_or_serial_bit_in_i,
                        retransmit_mark: retransmit_mark_i, replay_from_mark: replay_from_mark_i,
                        a_ctl: '{cs_n: a_side_chip_select_n_i, gate: a_side_master_gate_i,
                                 dir: a_side_write_not_read_i, mbx: a_side_mailbox_select_i},
                        b_ctl: '{cs_n: b_side_chip_select_n_i, gate: b_side_master_gate_i,
                                 dir: b_side_read_not_write_i, mbx: b_side_mailbox_select_i},
                        a_data: a_side_data_bus_i, b_data: b_side_data_bus_i};

    dcm_sync #(
        .WIDTH ($bits(dcm_pins_type))
    ) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .d_i     (pins_raw),
        .q_o     (pins_s)
    );

    // edge detection; port clocks must run well below half of clk_i
    wire a_rise  = pins_s.a_clk & ~a_clk_d_ff; // R4
    wire b_rise  = pins_s.b_clk & ~b_clk_d_ff; // R4
    wire rst_rel = pins_s.rst_n & ~rst_n_d_ff; // R8
    wire dev_rst = ~pins_s.rst_n; // R7

    wire a_req      = a_rise & ~pins_s.a_ctl.cs_n & pins_s.a_ctl.gate; // R5 R6
    wire a_wr       = a_req & pins_s.a_ctl.dir;
    wire a_rd       = a_req & ~pins_s.a_ctl.dir;
    wire a_fifo_wr  = a_wr & ~pins_s.a_ctl.mbx & input_accept_flag_o; // R25 R12
    wire a_mbx_wr   = a_wr & pins_s.a_ctl.mbx; // R14
    wire a_mbx_rd   = a_rd & pins_s.a_ctl.mbx; // R14
    wire mem_wr     = a_fifo_wr & (cfg_ff == CFG_RUN);

    wire b_req      = b_rise & ~pins_s.b_ctl.cs_n & pins_s.b_ctl.gate; // R5 R6
    wire b_rd       = b_req & pins_s.b_ctl.dir;
    wire b_wr       = b_req & ~pins_s.b_ctl.dir;
    wire b_fifo_rd  = b_rd & ~pins_s.b_ctl.mbx & output_valid_flag_o; // R26 R18
    wire b_mbx_rd   = b_rd & pins_s.b_ctl.mbx;
    wire b_mbx_wr   = b_wr & pins_s.b_ctl.mbx;

    // retransmit keeps the marked slot out of reach of the writer
    wire [10:0] free_ptr   = rtx_ff ? mark_ptr_ff : rd_ptr_ff; // R12
    wire [10:0] wr_ptr_inc = wr_ptr_ff + DCM_PTR_ONE; // R28
    wire [10:0] used_next  = dcm_ptr_diff(mem_wr ? wr_ptr_inc : wr_ptr_ff, free_a2_ff);
    wire [10:0] free_locs  = dcm_ptr_diff(DCM_DEPTH_PTR, used_next);
    wire        full_next  = (used_next == DCM_DEPTH_PTR); // R12

    wire        empty_b    = (rd_ptr_ff == wr_b2_ff); // R18
    wire        replay     = b_rise & rtx_ff & pins_s.replay_from_mark; // R22
    wire        fetch      = b_rise & ~replay & ~empty_b & (~output_valid_flag_o | b_fifo_rd);
    wire [10:0] rd_ptr_inc = rd_ptr_ff + DCM_PTR_ONE; // R28
    wire [10:0] mark_inc   = mark_ptr_ff + DCM_PTR_ONE;
    wire [10:0] cur_word   = rd_ptr_ff - DCM_PTR_ONE;
    wire [10:0] stored_b   = dcm_ptr_diff(wr_b2_ff, rd_ptr_ff) + {10'h000, output_valid_flag_o};
    wire [9:0]  rd_addr    = replay ? mark_ptr_ff[9:0] : rd_ptr_ff[9:0];

    wire [19:0] ofs_chain  = {full_ofs_ff, empty_ofs_ff};
    wire [19:0] ofs_shift  = {ofs_chain[18:0], pins_s.fs_lo}; // R10 R11
    wire        shift_en   = (cfg_ff == CFG_SERIAL) & a_rise & ~pins_s.fs_hi
                             & (bit_cnt_ff != DCM_SERIAL_BITS); // R9 R10
    wire [1:0]  fs_pair    = {pins_s.fs_hi, pins_s.fs_lo};

    dcm_mem #(
        .DATA_W (DCM_DATA_W),
        .ADDR_W (DCM_ADDR_W)
    ) u_mem (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .wr_en_i   (mem_wr),
        .wr_addr_i (wr_ptr_ff[9:0]),
        .wr_data_i (pins_s.a_data),
        .rd_en_i   (fetch | replay),
        .rd_addr_i (rd_addr),
        .rd_data_o (mem_q)
    );

    always_comb begin
        nxt_cfg = cfg_ff;
        unique case (cfg_ff)
            CFG_HOLD: begin
                if (rst_rel) begin
                    nxt_cfg = (fs_pair == DCM_FS_SERIAL) ? CFG_SERIAL : CFG_WAIT; // R8 R23
                end
            end
            CFG_WAIT: begin
                if (a_rise && (wait_cnt_ff == DCM_IR_WAIT_EDGES - 2'h1)) begin
                    nxt_cfg = par_mode_ff ? CFG_LOAD_FULL : CFG_RUN; // R13
                end
            end
            CFG_SERIAL: begin
                if (a_rise && (bit_cnt_ff == DCM_SERIAL_BITS)) begin
                    nxt_cfg = CFG_RUN; // R11
                end
            end
            CFG_LOAD_FULL: begin
                if (a_fifo_wr) begin
                    nxt_cfg = CFG_LOAD_EMPTY; // R24
                end
            end
            CFG_LOAD_EMPTY: begin
                if (a_fifo_wr) begin
                    nxt_cfg = CFG_RUN; // R24
                end
            end
            CFG_RUN: begin
                nxt_cfg = CFG_RUN;
            end
        endcase
        if (dev_rst) begin
            nxt_cfg = CFG_HOLD;
        end
    end

    // accept flag only rises in states that take writes
    always_comb begin
        nxt_ir = input_accept_flag_o;
        if (a_rise) begin
            nxt_ir = (nxt_cfg == CFG_LOAD_FULL || nxt_cfg == CFG_LOAD_EMPTY || nxt_cfg == CFG_RUN)
                     & ~full_next; // R12 R13
        end
        if (dev_rst) begin
            nxt_ir = 1'b0; // R13
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            a_clk_d_ff <= 1'b0;
            b_clk_d_ff <= 1'b0;
            rst_n_d_ff <= 1'b0;
            cfg_ff     <= CFG_HOLD;
        end else begin
            a_clk_d_ff <= pins_s.a_clk;
            b_clk_d_ff <= pins_s.b_clk;
            rst_n_d_ff <= pins_s.rst_n;
            cfg_ff     <= nxt_cfg;
        end
    end

    // offset programming
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            par_mode_ff  <= 1'b0;
            wait_cnt_ff  <= 2'h0;
            bit_cnt_ff   <= 5'h00;
            full_ofs_ff  <= DCM_OFS_RESET;
            empty_ofs_ff <= DCM_OFS_RESET;
        end else if (cfg_ff == CFG_HOLD) begin
            wait_cnt_ff <= 2'h0;
            bit_cnt_ff  <= 5'h00;
            if (rst_rel) begin
                par_mode_ff <= (fs_pair == 2'h0); // R23
                if (fs_pair == DCM_FS_PRESET_HI) begin
                    full_ofs_ff  <= DCM_PRESET_HI_OFS; // R23
                    empty_ofs_ff <= DCM_PRESET_HI_OFS;
                end else if (fs_pair == DCM_FS_PRESET_LO) begin
                    full_ofs_ff  <= DCM_PRESET_LO_OFS; // R23
                    empty_ofs_ff <= DCM_PRESET_LO_OFS;
                end
            end
        end else begin
            if (a_rise && cfg_ff == CFG_WAIT) begin
                wait_cnt_ff <= wait_cnt_ff + 2'h1;
            end
            if (shift_en) begin
                {full_ofs_ff, empty_ofs_ff} <= ofs_shift; // R10 R11
                bit_cnt_ff                  <= bit_cnt_ff + 5'h01;
            end
            if (a_fifo_wr && cfg_ff == CFG_LOAD_FULL) begin
                full_ofs_ff <= pins_s.a_data[9:0]; // R24
            end
            if (a_fifo_wr && cfg_ff == CFG_LOAD_EMPTY) begin
                empty_ofs_ff <= pins_s.a_data[9:0]; // R24
            end
        end
    end

    // side a: write pointer, view of the freed pointer, near full flag
    always_ff @(posedge clk_i) begin
        if (reset_i || dev_rst) begin
            wr_ptr_ff           <= DCM_PTR_RESET; // R28
            free_a1_ff          <= DCM_PTR_RESET;
            free_a2_ff          <= DCM_PTR_RESET;
            near_full_flag_n_o  <= 1'b1;
        end else if (a_rise) begin
            free_a1_ff         <= free_ptr; // R27
            free_a2_ff         <= free_a1_ff; // R27
            near_full_flag_n_o <= ~(free_locs <= {1'b0, full_ofs_ff}); // R2 R4
            if (mem_wr) begin
                wr_ptr_ff <= wr_ptr_inc;
            end
        end
    end

    // side b: read pointer, view of the write pointer, retransmit
    always_ff @(posedge clk_i) begin
        if (reset_i || dev_rst) begin
            rd_ptr_ff   <= DCM_PTR_RESET; // R28
            wr_b1_ff    <= DCM_PTR_RESET;
            wr_b2_ff    <= DCM_PTR_RESET;
            mark_ptr_ff <= DCM_PTR_RESET;
            rtx_ff      <= 1'b0;
            near_empty_flag_n_o <= 1'b0;
        end else if (b_rise) begin
            wr_b1_ff            <= wr_ptr_ff; // R27
            wr_b2_ff            <= wr_b1_ff; // R27
            near_empty_flag_n_o <= ~(stored_b <= {1'b0, empty_ofs_ff}); // R1 R4
            if (!pins_s.retransmit_mark) begin
                rtx_ff <= 1'b0; // R21
            end else if (output_valid_flag_o && !rtx_ff) begin
                rtx_ff      <= 1'b1; // R20
                mark_ptr_ff <= cur_word; // R20
            end
            if (replay) begin
                rd_ptr_ff <= mark_inc; // R22
            end else if (fetch) begin
                rd_ptr_ff <= rd_ptr_inc;
            end
        end
    end

    // output register follows the memory one cycle after a fetch
    always_ff @(posedge clk_i) begin
        if (reset_i || dev_rst) begin
            load_pend_ff        <= 1'b0;
            out_reg_ff          <= DCM_WORD_RESET;
            output_valid_flag_o <= 1'b0; // R19
            input_accept_flag_o <= 1'b0;
        end else begin
            load_pend_ff        <= fetch | replay;
            input_accept_flag_o <= nxt_ir;
            if (load_pend_ff) begin
                out_reg_ff          <= mem_q; // R22
                output_valid_flag_o <= 1'b1; // R18 R19
            end else if (b_fifo_rd && !fetch && !replay) begin
                output_valid_flag_o <= 1'b0; // R18
            end
        end
    end

    // mailboxes; the write wins when a read of the same box coincides
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mbx_to_b_ff <= DCM_WORD_RESET;
            mbx_to_a_ff <= DCM_WORD_RESET;
        end else begin
            if (a_mbx_wr) begin
                mbx_to_b_ff <= pins_s.a_data; // R14
            end
            if (b_mbx_wr) begin
                mbx_to_a_ff <= pins_s.b_data;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i || dev_rst) begin
            mail_to_b_flag_n_o <= 1'b1; // R16
            mail_to_a_flag_n_o <= 1'b1; // R17
        end else begin
            if (a_mbx_wr) begin
                mail_to_b_flag_n_o <= 1'b0; // R16
            end else if (b_mbx_rd) begin
                mail_to_b_flag_n_o <= 1'b1; // R16
            end
            if (b_mbx_wr) begin
                mail_to_a_flag_n_o <= 1'b0; // R17
            end else if (a_mbx_rd) begin
                mail_to_a_flag_n_o <= 1'b1; // R17
            end
        end
    end

    // bus drivers; side a reads only ever show the mailbox to a
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            a_side_data_bus_o    <= DCM_WORD_RESET;
            a_side_data_bus_oe_o <= 1'b0;
            b_side_data_bus_o    <= DCM_WORD_RESET;
            b_side_data_bus_oe_o <= 1'b0;
        end else begin
            a_side_data_bus_o    <= mbx_to_a_ff; // R3
            a_side_data_bus_oe_o <= ~pins_s.a_ctl.cs_n & ~pins_s.a_ctl.dir; // R5
            b_side_data_bus_o    <= pins_s.b_ctl.mbx ? mbx_to_b_ff : out_reg_ff; // R15 R3
            b_side_data_bus_oe_o <= ~pins_s.b_ctl.cs_n & pins_s.b_ctl.dir; // R5
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_ir_reset: assert property (dev_rst |=> !input_accept_flag_o) // R13
        else $error("accept flag high during reset");
    chk_or_reset: assert property (dev_rst |=> !output_valid_flag_o) // R19
        else $error("valid flag high during reset");
    chk_no_overflow: assert property (dcm_ptr_diff(wr_ptr_ff, free_ptr) <= DCM_DEPTH_PTR) // R12
        else $error("fifo holds more words than its depth");
    chk_mail_b_write: assert property (a_mbx_wr && !dev_rst |=>
        !mail_to_b_flag_n_o && mbx_to_b_ff == $past(pins_s.a_data)) // R16
        else $error("mailbox to b write not seen");
    chk_mail_b_read: assert property (b_mbx_rd && !a_mbx_wr |=> mail_to_b_flag_n_o) // R16
        else $error("mailbox to b flag not raised by read");
    chk_mail_a_write: assert property (b_mbx_wr && !dev_rst |=> !mail_to_a_flag_n_o) // R17
        else $error("mailbox to a flag not lowered");
    chk_b_bus_select: assert property (!pins_s.b_ctl.cs_n && pins_s.b_ctl.mbx |=>
        b_side_data_bus_o == $past(mbx_to_b_ff)) // R15
        else $error("side b bus not showing mailbox");
    chk_bus_float: assert property (pins_s.a_ctl.cs_n |=> !a_side_data_bus_oe_o) // R5
        else $error("side a bus driven while deselected");
    chk_gate_low: assert property (!pins_s.a_ctl.gate && !dev_rst |=> $stable(wr_ptr_ff)) // R6
        else $error("write taken with gate low");
    chk_fetch_valid: assert property (fetch && !dev_rst ##1 !dev_rst |=> output_valid_flag_o) // R19
        else $error("fetched word not marked valid");
    chk_replay_ptr: assert property (replay && !dev_rst |=> rd_ptr_ff == $past(mark_inc)) // R22
        else $error("replay did not rewind read pointer");
    chk_serial_done: assert property (cfg_ff == CFG_SERIAL && a_rise && !dev_rst
        && bit_cnt_ff == DCM_SERIAL_BITS |=> input_accept_flag_o) // R11
        else $error("accept flag not raised after serial load");

    cov_fetch: cover property (fetch ##[1:40] b_fifo_rd);
    cov_replay: cover property (rtx_ff ##[1:200] replay);
    cov_serial: cover property (cfg_ff == CFG_SERIAL ##[1:1000] cfg_ff == CFG_RUN);
    cov_mail: cover property (a_mbx_wr ##[1:100] b_mbx_rd);
endmodule

// File: test/dcm_host_model.sv
// host side model: free running port clock and two-way bus level
`timescale 1ns/100ps
module dcm_host_model #(
    parameter int HALF_NS = 32
) (
    input  wire logic        drv_en_i,
    input  wire logic [35:0] drv_data_i,
    input  wire logic        dev_oe_i,
    input  wire logic [35:0] dev_data_i,
    output logic             port_clock_o,
    output logic      [35:0] bus_level_o
);
    logic [35:0] last_ff = 36'h0;
    // released bus shows the inverse of its last level, never a stale copy
    assign bus_level_o = dev_oe_i ? dev_data_i : (drv_en_i ? drv_data_i : ~last_ff);
    always_ff @(posedge port_clock_o) begin
        if (dev_oe_i || drv_en_i) begin
            last_ff <= bus_level_o;
        end
    end
    initial begin
        port_clock_o = 1'h0;
        // offset keeps every port edge off the system clock edges, no sampling race
        #1;
        forever #HALF_NS port_clock_o = ~port_clock_o;
    end
endmodule

// File: test/tb.sv
// self-checking bench for the dual clock mailbox fifo
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb
    import dcm_pkg::*;
;
    typedef struct packed {
        logic             s;
        dcm_port_ctl_type c;
        logic [35:0]      d;
        logic [2:0]       f;
        logic [35:0]      w;
    } dcm_row_type;
    logic             clk_i   = 1'h0;
    logic             reset_i = 1'h1;
    logic             rst_n   = 1'h0;
    logic             retransmit_mark     = 1'h0;
    logic             replay_from_mark     = 1'h0;
    logic      [1:0]  fs      = 2'h2;
    dcm_port_ctl_type a_ctl   = 4'h8;
    dcm_port_ctl_type b_ctl   = 4'h2;
    logic      [35:0] a_drv   = 36'h0;
    logic      [35:0] b_drv   = 36'h0;
    logic      [35:0] a_bus, b_bus, a_o, b_o;
    logic             a_clk, b_clk, a_oe, b_oe, ir, nf_n, ov, ne_n, mb_n, ma_n;
    int               num_errors = 0;
    int               checked    = 0;
    // f holds valid, mail to b, mail to a; w is the bus output of the row's side
    dcm_row_type rows [10] = '{
        '{1'h0, 4'h6, 36'h9_1234_5678, 3'h7, 36'h0},
        '{1'h0, 4'he, 36'h1, 3'h7, 36'h0},
        '{1'h0, 4'h2, 36'h2, 3'h7, 36'h0},
        '{1'h0, 4'h7, 36'ha_5a5a_5a5a, 3'h5, 36'h0},
        '{1'h0, 4'h6, 36'h0_dead_beef, 3'h5, 36'h0},
        '{1'h1, 4'h2, 36'h0, 3'h5, 36'h9_1234_5678},
        '{1'h1, 4'h6, 36'h0, 3'h5, 36'h0_dead_beef},
        '{1'h1, 4'h7, 36'h0, 3'h7, 36'ha_5a5a_5a5a},
        '{1'h1, 4'h5, 36'h5_a5a5_a5a5, 3'h6, 36'ha_5a5a_5a5a},
        '{1'h0, 4'h5, 36'h0, 3'h7, 36'h5_a5a5_a5a5}};
    dcm_mailbox_fifo u_dcm_mailbox_fifo (
        .clk_i(clk_i), .reset_i(reset_i), .a_side_clock_i(a_clk), .b_side_clock_i(b_clk),
        .device_reset_n_i(rst_n), .offset_select_hi_or_serial_shift_gate_i(fs[1]),
        .offset_select_lo_or_serial_bit_in_i(fs[0]), .retransmit_mark_i(retransmit_mark), .replay_from_mark_i(replay_from_mark),
        .a_side_chip_select_n_i(a_ctl.cs_n), .a_side_master_gate_i(a_ctl.gate),
        .a_side_write_not_read_i(a_ctl.dir), .a_side_mailbox_select_i(a_ctl.mbx),
        .b_side_chip_select_n_i(b_ctl.cs_n), .b_side_master_gate_i(b_ctl.gate),
        .b_side_read_not_write_i(b_ctl.dir), .b_side_mailbox_select_i(b_ctl.mbx),
        .a_side_data_bus_i(a_bus), .a_side_data_bus_o(a_o), .a_side_data_bus_oe_o(a_oe),
        .b_side_data_bus_i(b_bus), .b_side_data_bus_o(b_o), .b_side_data_bus_oe_o(b_oe),
        .input_accept_flag_o(ir), .near_full_flag_n_o(nf_n), .output_valid_flag_o(ov),
        .near_empty_flag_n_o(ne_n), .mail_to_b_flag_n_o(mb_n), .mail_to_a_flag_n_o(ma_n));
    dcm_host_model #(.HALF_NS(32)) host_a (.drv_en_i(!a_ctl.cs_n && a_ctl.dir), .drv_data_i(a_drv),
        .dev_oe_i(a_oe), .dev_data_i(a_o), .port_clock_o(a_clk), .bus_level_o(a_bus));
    dcm_host_model #(.HALF_NS(36)) host_b (.drv_en_i(!b_ctl.cs_n && !b_ctl.dir), .drv_data_i(b_drv),
        .dev_oe_i(b_oe), .dev_data_i(b_o), .port_clock_o(b_clk), .bus_level_o(b_bus));
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // changes land mid port cycle so the oversampler never sees them race the edge
    task automatic pe(input logic s);
        if (s) @(negedge b_clk);
        else @(negedge a_clk);
        @(posedge clk_i);
        #1;
    endtask
    task automatic op(input logic s, input dcm_port_ctl_type c, input logic [35:0] d);
        pe(s);
        if (s) {b_ctl, b_drv} = {c, d};
        else {a_ctl, a_drv} = {c, d};
        pe(s);
        if (s) b_ctl.gate = 1'h0;
        else a_ctl.gate = 1'h0;
        #384;
    endtask
    initial forever #4 clk_i = ~clk_i;
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        reset_i = 1'h0;
        repeat (60) @(posedge clk_i);
        #1;
        `CHK({ir, ov, mb_n, ma_n, nf_n, ne_n}, 6'h0e)
        rst_n = 1'h1;
        for (int k = 0; k < 200 && ir !== 1'h1; k++) #8;
        `CHK(ir, 1'h1)
        foreach (rows[i]) begin
            op(rows[i].s, rows[i].c, rows[i].d);
            `CHK({ov, mb_n, ma_n}, rows[i].f)
            `CHK(rows[i].s ? b_o : a_o, rows[i].w)
        end
        op(1'h1, 4'h6, 36'h0);
        `CHK(ov, 1'h0)
        for (int i = 1; i <= 66; i++) begin
            op(1'h0, 4'h6, 36'(i));
            `CHK({ne_n, nf_n}, {1'(i > 64), 1'h1})
        end
        retransmit_mark = 1'h1;
        repeat (2) pe(1'h1);
        op(1'h1, 4'h6, 36'h0);
        op(1'h1, 4'h6, 36'h0);
        `CHK(b_o, 36'h3)
        replay_from_mark = 1'h1;
        pe(1'h1);
        replay_from_mark = 1'h0;
        retransmit_mark = 1'h0;
        #384;
        `CHK(b_o, 36'h1)
        for (int i = 1; i <= 66; i++) begin
            `CHK(b_o, 36'(i))
            op(1'h1, 4'h6, 36'h0);
            `CHK(ne_n, 1'(66 - i > 64))
        end
        `CHK(ov, 1'h0)
        op(1'h0, 4'h7, 36'h7);
        `CHK(mb_n, 1'h0)
        rst_n = 1'h0;
        fs    = 2'h3;
        #640;
        `CHK({ir, ov, ne_n, mb_n}, 4'h1)
        rst_n = 1'h1;
        pe(1'h0);
        // offsets of one each: bit ten and bit zero of the chain are set
        for (int i = 0; i < 20; i++) begin
            fs = {1'h0, i % 10 == 9};
            pe(1'h0);
        end
        fs = 2'h3;
        `CHK(ir, 1'h0)
        pe(1'h0);
        `CHK(ir, 1'h1)
        op(1'h0, 4'h6, 36'h1);
        `CHK(ne_n, 1'h0)
        op(1'h0, 4'h6, 36'h2);
        `CHK(ne_n, 1'h1)
        close_out();
    end
endmodule
